// ---- terfe_pkg.sv ----
package terfe_pkg;

   // Word index of each register on the Avalon-MM slave (word addressing).
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_LCV_COUNT = 2'h2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Bit positions inside the control register.
   localparam int CTRL_UNIPOLAR = 0;
   localparam int CTRL_AMI = 1;
   localparam int CTRL_E3 = 2;
   localparam int CTRL_SAMPLE_RISE = 3;
   localparam int CTRL_FIFO_EN = 4;
   localparam int CTRL_CLK_INV = 5;
   localparam int CTRL_OVH_MARKER = 6;
   localparam int CTRL_ALL_ONES = 7;
   localparam int CTRL_AIS = 8;
   localparam int CTRL_AUTO_ONES = 9;
   localparam int CTRL_ALL_OVH_GAP = 10;
   localparam int CTRL_JUST_GAP = 11;
   localparam int CTRL_STUFF_GAP = 12;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_1fff;

   // Bit positions inside the status register.
   localparam int STAT_FILL_LSB = 0;
   localparam int STAT_PRIMED = 5;
   localparam int STAT_AUTO_ACTIVE = 6;

   // Dejitter buffer geometry; reading starts at half fill to absorb jitter both ways.
   localparam int FIFO_AW = 4;
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] FIFO_START = 5'h08;

   // Decoded bits cleared when a zero substitution is recognised.
   localparam logic [3:0] SUB_MASK_B3ZS = 4'h3;
   localparam logic [3:0] SUB_MASK_HDB3 = 4'h7;

   typedef enum logic [1:0] {CLS_PAYLOAD, CLS_OVERHEAD, CLS_JUSTIFY, CLS_STUFF} terfe_class_t;
   typedef enum logic [1:0] {LM_RAIL, LM_AMI, LM_UNIPOLAR} terfe_line_mode_t;
   typedef enum logic {BUS_IDLE, BUS_ACK} terfe_bus_state_t;

   // Framing template for the bit presented on the internal stream.
   typedef struct packed {
      terfe_class_t bit_class;
      logic frame_first;
      logic sync_end;
      logic mark_en;
   } terfe_tpl_t;

   // Receive alarm states reported by the framing logic.
   typedef struct packed {
      logic los;
      logic oof;
      logic ais;
      logic idle;
   } terfe_alarm_t;

endpackage : terfe_pkg

// ---- terfe_receive_front_end.sv ----
// Overview of operation
// RULE1 - Rail, AMI or unipolar line mode selectable.
// RULE2 - Sample line inputs on chosen clock edge.
// RULE3 - AMI: any rail high gives one.
// RULE4 - B3ZS: 100V or 110V become 1000.
// RULE5 - HDB3: 1000V or 1100V become 10000.
// RULE6 - Bipolar decode to unipolar, flag violations.
// RULE7 - Unipolar mode bypasses decoder, uses positive rail.
// RULE8 - Line unit drives negative rail as violation.
// RULE9 - Buffer on: line clock in, dejittered out.
// RULE10 - Buffer off: line clock drives everything.
// RULE11 - Outputs change on internal clock rising edge.
// RULE12 - Output clocks optionally inverted.
// RULE13 - System captures outputs on opposite edge.
// RULE14 - Every payload and overhead bit output.
// RULE15 - Gapped clock has five selectable modes.
// RULE16 - Justification and stuff bits count as overhead.
// RULE17 - Frame sync rises first bit, falls after end.
// RULE18 - Marker mode: low overhead, high payload.
// RULE19 - Forced all-ones or AIS masks data.
// RULE20 - Auto all-ones while LOS, OOF, AIS, Idle; the code counts Idle only while the E3 bit is clear.
// RULE21 - Masking leaves internal stream untouched.
// RULE22 - Outputs follow old alignment during out-of-frame.
// RULE23 - Sixteen-bit buffer after decoder absorbs jitter.
// RULE24 - Buffer bypassed when its enable clears.
// RULE25 - Gap mode chosen by gap control fields.
// RULE26 - One-cycle pulse per violation for monitoring.
// RULE27 - One output clock pulse per data bit.
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module terfe_receive_front_end (
   input wire logic clk_sys_in, // System clock, 250 MHz.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [1:0] avs_address_in, // Register word index.
   input wire logic avs_read_in, // Read request.
   input wire logic avs_write_in, // Write request.
   input wire logic [31:0] avs_writedata_in, // Write data.
   input wire logic [3:0] avs_byteenable_in, // Write byte lanes.
   output logic [31:0] avs_readdata_out, // Read data.
   output logic avs_waitrequest_out, // Stall while the answer is built.
   input wire logic raw_line_clock_in, // Raw clock recovered from the line.
   input wire logic dejittered_clock_in, // Smoothed line clock, low when unused.
   input wire logic positive_rail_in, // Positive rail, or unipolar data.
   input wire logic negative_rail_in, // Negative rail, or external violation.
   input wire terfe_pkg::terfe_tpl_t tpl_in, // Template of the bit now presented.
   input wire terfe_pkg::terfe_alarm_t alarm_in, // Alarm states from framing.
   output logic rx_bit_strobe_out, // One-cycle strobe per internal bit.
   output logic rx_bit_data_out, // Unmasked internal stream bit.
   output logic line_code_violation_out, // One-cycle pulse per violation.
   output logic serial_data_out, // Serial data to the system.
   output logic gapped_data_clock_out, // Gapped data clock.
   output logic marking_clock_out, // Marking clock.
   output logic frame_sync_out // Frame sync or overhead marker.
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   localparam int FIFO_AW_L = terfe_pkg::FIFO_AW;
   logic [1:0] lck_sync_ff, dck_sync_ff, pos_sync_ff, neg_sync_ff;
   logic lck_prev_ff, int_prev_ff, out_lvl_ff;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [15:0] lcv_cnt_ff;
   terfe_pkg::terfe_bus_state_t bus_st_ff;
   logic [3:0] hist_ff;
   logic last_pos_ff, have_mark_ff, lcv_ff, lb_vld_ff, lb_dat_ff;
   logic [15:0] fifo_mem_ff;
   logic [FIFO_AW_L-1:0] wr_ptr_ff, rd_ptr_ff;
   logic [4:0] fifo_cnt_ff;
   logic primed_ff;
   logic data_ff, gate_ff, mark_ff, fs_ff, sync_end_ff, ais_phase_ff;

   // Decode of the line mode is written as a function; only the mode wire uses it.
   function automatic terfe_pkg::terfe_line_mode_t line_mode(input logic [31:0] c);
      if (c[terfe_pkg::CTRL_UNIPOLAR]) begin
         line_mode = terfe_pkg::LM_UNIPOLAR;
      end else if (c[terfe_pkg::CTRL_AMI]) begin
         line_mode = terfe_pkg::LM_AMI;
      end else begin
         line_mode = terfe_pkg::LM_RAIL;
      end
   endfunction : line_mode

   ////////////////////////////////////////////////////////////////////////////
   // Control fields.
   wire terfe_pkg::terfe_line_mode_t mode = line_mode(ctrl_ff); // RULE1
   wire is_e3 = ctrl_ff[terfe_pkg::CTRL_E3];
   wire fifo_en = ctrl_ff[terfe_pkg::CTRL_FIFO_EN];
   wire clk_inv = ctrl_ff[terfe_pkg::CTRL_CLK_INV];
   wire ovh_marker = ctrl_ff[terfe_pkg::CTRL_OVH_MARKER];

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read by any logic.
   always_ff @(posedge clk_sys_in) begin
      lck_sync_ff <= {lck_sync_ff[0], raw_line_clock_in};
      dck_sync_ff <= {dck_sync_ff[0], dejittered_clock_in};
      pos_sync_ff <= {pos_sync_ff[0], positive_rail_in};
      neg_sync_ff <= {neg_sync_ff[0], negative_rail_in};
   end

   // Line sampling edge is picked by the sample edge field.
   wire lck = lck_sync_ff[1];
   wire lck_rise = lck & ~lck_prev_ff;
   wire lck_fall = ~lck & lck_prev_ff;
   wire line_tick = ctrl_ff[terfe_pkg::CTRL_SAMPLE_RISE] ? lck_rise : lck_fall; // RULE2
   wire p_s = pos_sync_ff[1];
   wire n_s = neg_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // Bipolar decoder. A mark on the same rail as the last one, or on both rails, is a
   // violation. A violation that completes a zero substitution is folded back to zeros.
   wire mark = p_s | n_s; // RULE3
   wire viol = (p_s & n_s) | (have_mark_ff & ((p_s & last_pos_ff) | (n_s & ~last_pos_ff)));
   wire sub_room = is_e3 ? (~hist_ff[0] & ~hist_ff[1]) : ~hist_ff[0];
   wire subst = (mode == terfe_pkg::LM_RAIL) & mark & viol & sub_room; // RULE4 RULE5
   wire [3:0] sub_mask = is_e3 ? terfe_pkg::SUB_MASK_HDB3 : terfe_pkg::SUB_MASK_B3ZS;
   wire [3:0] hist_kept = subst ? (hist_ff & ~sub_mask) : hist_ff;
   wire cur_bit = mark & ~subst;
   wire dec_lcv = (mode == terfe_pkg::LM_UNIPOLAR) ? n_s : (mark & viol & ~subst); // RULE6
   // Unipolar bypass has no decoder delay; bipolar output lags by the window length.
   wire line_bit = (mode == terfe_pkg::LM_UNIPOLAR) ? p_s : hist_kept[3]; // RULE7

   // Decoder state and line bit register; in unipolar mode a tie-low negative rail never flags. // RULE8
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         lck_prev_ff <= 1'b0;
         hist_ff <= 4'h0;
         last_pos_ff <= 1'b0;
         have_mark_ff <= 1'b0;
         lcv_ff <= 1'b0;
         lb_vld_ff <= 1'b0;
         lb_dat_ff <= 1'b0;
      end else begin
         lck_prev_ff <= lck;
         lcv_ff <= line_tick & dec_lcv; // RULE26
         lb_vld_ff <= line_tick;
         if (line_tick) begin
            hist_ff <= {hist_kept[2:0], cur_bit};
            lb_dat_ff <= line_bit;
            if (mark) begin
               last_pos_ff <= p_s;
               have_mark_ff <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Dejitter buffer. Writes follow the line clock, reads the dejittered clock; reading
   // starts at half fill and stops on underflow, a full buffer drops the new bit.
   wire int_lvl = fifo_en ? dck_sync_ff[1] : lck; // RULE9 RULE10
   wire int_tick = int_lvl & ~int_prev_ff;
   wire fifo_full = (fifo_cnt_ff == terfe_pkg::FIFO_DEPTH);
   wire fifo_wr = fifo_en & lb_vld_ff & ~fifo_full; // RULE23
   wire fifo_rd = fifo_en & int_tick & primed_ff & (fifo_cnt_ff != 5'h00);
   wire stream_bit = fifo_en ? (fifo_rd & fifo_mem_ff[rd_ptr_ff]) : lb_dat_ff; // RULE24
   wire [4:0] nxt_cnt = fifo_cnt_ff + {4'h0, fifo_wr} - {4'h0, fifo_rd};

   // Buffer pointers, fill level and priming; all cleared while the buffer is off.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !fifo_en) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         fifo_cnt_ff <= 5'h00;
         primed_ff <= 1'b0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + FIFO_AW_L'(fifo_wr);
         rd_ptr_ff <= rd_ptr_ff + FIFO_AW_L'(fifo_rd);
         fifo_cnt_ff <= nxt_cnt;
         primed_ff <= (nxt_cnt >= terfe_pkg::FIFO_START) | (primed_ff & (nxt_cnt != 5'h00));
      end
   end

   // Buffer storage has no reset; unread cells never reach the outputs.
   always_ff @(posedge clk_sys_in) begin
      if (fifo_wr) begin
         fifo_mem_ff[wr_ptr_ff] <= lb_dat_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System side selection. The template comes from framing logic that keeps the old
   // alignment during out-of-frame, so only the auto all-ones selection here reacts to the oof alarm. // RULE22
   wire is_payload = (tpl_in.bit_class == terfe_pkg::CLS_PAYLOAD); // RULE16
   wire is_just = (tpl_in.bit_class == terfe_pkg::CLS_JUSTIFY);
   wire is_stuff = (tpl_in.bit_class == terfe_pkg::CLS_STUFF);
   wire gap_on = ctrl_ff[terfe_pkg::CTRL_ALL_OVH_GAP];
   wire gate_sel = ~gap_on | is_payload | (is_just & ctrl_ff[terfe_pkg::CTRL_JUST_GAP])
                   | (is_stuff & ctrl_ff[terfe_pkg::CTRL_STUFF_GAP]); // RULE15 RULE25
   wire auto_hit = alarm_in.los | alarm_in.oof | alarm_in.ais | (alarm_in.idle & ~is_e3);
   wire auto_ones = ctrl_ff[terfe_pkg::CTRL_AUTO_ONES] & auto_hit; // RULE20
   wire ones_sel = ctrl_ff[terfe_pkg::CTRL_ALL_ONES] | auto_ones;
   // E3 AIS is all ones; DS3 AIS alternates on payload and keeps overhead intact.
   wire ais_bit = is_e3 | ~is_payload ? (is_e3 | stream_bit) : ais_phase_ff;
   wire out_bit = ones_sel ? 1'b1 : (ctrl_ff[terfe_pkg::CTRL_AIS] ? ais_bit : stream_bit); // RULE19
   wire fs_frame = tpl_in.frame_first | (fs_ff & ~sync_end_ff);
   wire fs_next = ovh_marker ? is_payload : fs_frame; // RULE17 RULE18

   // Internal stream to framing and monitoring is taken before any masking. // RULE21
   assign rx_bit_strobe_out = int_tick;
   assign rx_bit_data_out = stream_bit;

   // Output data, gate, marker and sync registers move only on the internal clock rising edge; the clock level follows every cycle. // RULE11 RULE14
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         int_prev_ff <= 1'b0;
         out_lvl_ff <= 1'b0;
         data_ff <= 1'b0;
         gate_ff <= 1'b0;
         mark_ff <= 1'b0;
         fs_ff <= 1'b0;
         sync_end_ff <= 1'b0;
         ais_phase_ff <= 1'b1;
      end else begin
         int_prev_ff <= int_lvl;
         out_lvl_ff <= int_lvl;
         if (int_tick) begin
            data_ff <= out_bit;
            gate_ff <= gate_sel;
            mark_ff <= tpl_in.mark_en;
            fs_ff <= fs_next;
            sync_end_ff <= tpl_in.sync_end;
            ais_phase_ff <= ais_phase_ff ^ is_payload;
         end
      end
   end

   // Clocks rise with the data update unless clk_inv is set, when they fall with it, so the system takes data on the other edge;
   // gates are loaded at that same rising edge, so a gate change coincides with the clock rising.
   assign gapped_data_clock_out = (out_lvl_ff & gate_ff) ^ clk_inv; // RULE12 RULE13 RULE27
   assign marking_clock_out = (out_lvl_ff & mark_ff) ^ clk_inv;
   assign serial_data_out = data_ff;
   assign frame_sync_out = fs_ff;
   assign line_code_violation_out = lcv_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: every access waits exactly one cycle.
   wire req = avs_read_in | avs_write_in;
   wire done = req & (bus_st_ff == terfe_pkg::BUS_ACK);
   wire wr_ctrl = done & avs_write_in & (avs_address_in == terfe_pkg::REG_CTRL);
   wire wr_cnt = done & avs_write_in & (avs_address_in == terfe_pkg::REG_LCV_COUNT);
   wire [31:0] status_word = {25'h000_0000, auto_ones, primed_ff, fifo_cnt_ff};
   wire [31:0] rd_mux = (avs_address_in == terfe_pkg::REG_CTRL) ? ctrl_ff :
                        (avs_address_in == terfe_pkg::REG_STATUS) ? status_word :
                        (avs_address_in == terfe_pkg::REG_LCV_COUNT) ? {16'h0000, lcv_cnt_ff} :
                        32'h0000_0000;
   assign avs_waitrequest_out = req & ~done;

   // Byte lanes of the control register.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign nxt_ctrl[8*g +: 8] = (wr_ctrl & avs_byteenable_in[g]) ?
            (avs_writedata_in[8*g +: 8] & terfe_pkg::CTRL_WMASK[8*g +: 8]) : ctrl_ff[8*g +: 8];
      end
   endgenerate

   // Bus state, registers and violation count; a clear together with a new violation leaves a count of one.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         bus_st_ff <= terfe_pkg::BUS_IDLE;
         ctrl_ff <= terfe_pkg::CTRL_RESET;
         lcv_cnt_ff <= 16'h0000;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         bus_st_ff <= (req & ~done) ? terfe_pkg::BUS_ACK : terfe_pkg::BUS_IDLE;
         ctrl_ff <= nxt_ctrl;
         if (req & ~done) begin
            avs_readdata_out <= rd_mux;
         end
         if (lcv_ff) begin
            lcv_cnt_ff <= (wr_cnt ? 16'h0000 : lcv_cnt_ff) + 16'h0001;
         end else if (wr_cnt) begin
            lcv_cnt_ff <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and covers.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   AST_AMI_MARK: assert property (line_tick && mode == terfe_pkg::LM_AMI && mark |=> hist_ff[0]) // RULE3
      else $error("AMI mark not decoded as one.");
   AST_UNIPOLAR_BYPASS: assert property (line_tick && mode == terfe_pkg::LM_UNIPOLAR
      |=> lb_dat_ff == $past(p_s)) // RULE7
      else $error("Unipolar data did not bypass the decoder.");
   AST_SUBST_SILENT: assert property (line_tick && subst |=> !lcv_ff && !hist_ff[0]) // RULE4
      else $error("Zero substitution flagged or not cleared.");
   AST_HDB3_CLEAR: assert property (line_tick && subst && is_e3 |=> hist_ff[3:0] == 4'h0
      || hist_ff[3] == $past(hist_ff[2])) // RULE5
      else $error("HDB3 substitution left marks in the window.");
   AST_LCV_PULSE: assert property (lcv_ff |=> !lcv_ff) // RULE26
      else $error("Violation pulse longer than one cycle.");
   AST_ALL_ONES: assert property (int_tick && ones_sel |=> serial_data_out) // RULE19
      else $error("Serial data not forced to one.");
   AST_UNGAPPED: assert property (int_tick && !gap_on |=> gate_ff [*2]) // RULE15
      else $error("Ungapped clock lost a pulse.");
   AST_MARKER: assert property (int_tick && ovh_marker
      |=> frame_sync_out == ($past(tpl_in.bit_class) == terfe_pkg::CLS_PAYLOAD)) // RULE18
      else $error("Overhead marker level wrong.");
   AST_FRAME_RISE: assert property (int_tick && !ovh_marker && tpl_in.frame_first
      |=> frame_sync_out) // RULE17
      else $error("Frame sync did not rise on first bit.");
   AST_DATA_STABLE: assert property (!int_tick |=> $stable(serial_data_out)) // RULE11
      else $error("Serial data changed off the internal clock edge.");
   AST_FIFO_BOUND: assert property (fifo_cnt_ff <= terfe_pkg::FIFO_DEPTH) // RULE23
      else $error("Dejitter buffer fill beyond depth.");
   AST_BUS_WAIT: assert property (req && bus_st_ff == terfe_pkg::BUS_IDLE
      |-> avs_waitrequest_out ##1 (!avs_waitrequest_out || !req))
      else $error("Bus answer not given after one wait cycle.");

   COV_SUBST: cover property (line_tick && subst);
   COV_PRIMED: cover property ($rose(primed_ff));
   COV_AUTO_ONES: cover property (int_tick && auto_ones);
   COV_FRAME: cover property ($rose(frame_sync_out) ##[1:200] $fell(frame_sync_out));

endmodule : terfe_receive_front_end

`default_nettype wire

// ---- terfe_line_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Line interface unit model: a free-running line clock and rails that change
// on the edge opposite the sampling edge, so each symbol is a full period wide.
module terfe_line_model (
   input wire logic sample_rise_in, // Device samples on the rising edge.
   input wire logic dejit_en_in, // Supply the smoothed clock.
   output logic raw_clk_out, // Raw line clock, 48 ns period.
   output logic dejit_clk_out, // Smoothed clock, low when unused.
   output logic pos_out, // Positive rail or unipolar data.
   output logic neg_out // Negative rail or external violation.
);
   logic lck = 1'b0;
   logic dly = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // The recovered line clock never stops; the smoothed copy lags it.
   always #24 lck = ~lck;
   always @(lck) dly <= #10 lck;
   assign raw_clk_out = lck;
   assign dejit_clk_out = dejit_en_in & dly;

   initial begin
      pos_out = 1'b0;
      neg_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One symbol per line period; in unipolar mode neg flags a violation.
   task send(input logic p, input logic n);
      if (sample_rise_in) begin
         @(negedge lck);
      end else begin
         @(posedge lck);
      end
      pos_out = p;
      neg_out = n;
   endtask : send
endmodule : terfe_line_model
`default_nettype wire

// ---- terfe_receive_front_end_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module terfe_receive_front_end_bench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wreq;
   terfe_pkg::terfe_tpl_t tpl = '0;
   terfe_pkg::terfe_alarm_t alarm = '0;
   logic srise = 1'b0;
   logic djen = 1'b0;
   logic raw, dj, pos, neg, strobe, bitd, viol, sdat, gclk, mclk, fsync;
   int fails = 0;
   int num_checks = 0;
   logic q[$];
   logic [31:0] v;
   logic [4:0] seen;
   // Gap cases: control word, template, expected {gap high, gap low, sync high}.
   logic [31:0] gctl [7] = '{32'h0000_0449, 32'h0000_0c49, 32'h0000_0449,
      32'h0000_0469, 32'h0000_0049, 32'h0000_0009, 32'h0000_1449};
   logic [4:0] gtpl [7] = '{5'h08, 5'h10, 5'h00, 5'h08, 5'h08, 5'h0c, 5'h18};
   logic [2:0] gexp [7] = '{3'h2, 3'h6, 3'h7, 3'h4, 3'h6, 3'h7, 3'h6};

   terfe_receive_front_end terfe_receive_front_end_i (
      .clk_sys_in(clk_sys), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .raw_line_clock_in(raw),
      .dejittered_clock_in(dj), .positive_rail_in(pos), .negative_rail_in(neg),
      .tpl_in(tpl), .alarm_in(alarm), .rx_bit_strobe_out(strobe), .rx_bit_data_out(bitd),
      .line_code_violation_out(viol), .serial_data_out(sdat), .gapped_data_clock_out(gclk),
      .marking_clock_out(mclk), .frame_sync_out(fsync));

   terfe_line_model terfe_line_model_i (
      .sample_rise_in(srise), .dejit_en_in(djen), .raw_clk_out(raw),
      .dejit_clk_out(dj), .pos_out(pos), .neg_out(neg));

   ////////////////////////////////////////////////////////////////////////
   // Clock, and capture of the unmasked internal stream.
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (strobe === 1'b1) q.push_back(bitd);

   task end_of_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Bus cycle: the request holds until a rising edge sees waitrequest low; data is
   // taken at that same edge, and only then is the request released.
   task acc(input logic w, input logic [1:0] a, input logic [31:0] d,
            output logic [31:0] r);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_sys);
      end while (wreq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : acc

   task cfg(input logic [31:0] c);
      srise = c[terfe_pkg::CTRL_SAMPLE_RISE];
      djen = c[terfe_pkg::CTRL_FIFO_EN];
      acc(1'b1, terfe_pkg::REG_CTRL, c, v);
   endtask : cfg

   // Symbols are {pos, neg} pairs, first symbol in the top pair; zero padding
   // around them lets the decoder window and the buffer flush.
   task line(input logic [31:0] s, input int n);
      int i;
      for (i = 0; i < 12; i++) terfe_line_model_i.send(1'b0, 1'b0);
      for (i = n - 1; i >= 0; i--) terfe_line_model_i.send(s[2*i+1], s[2*i]);
      for (i = 0; i < 12; i++) terfe_line_model_i.send(1'b0, 1'b0);
   endtask : line

   function automatic logic has(input logic [15:0] p, input int n);
      int i;
      int j;
      logic ok;
      for (i = 0; i + n <= q.size(); i++) begin
         ok = 1'b1;
         for (j = 0; j < n; j++) if (q[i+j] !== p[n-1-j]) ok = 1'b0;
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction : has

   // A negative priming pulse fixes the last polarity before the count is cleared.
   task run(input logic [31:0] c, input logic [31:0] s, input int n,
            input logic [15:0] p, input int np, input logic [31:0] cnt);
      cfg(c);
      line(32'h0000_0001, 1);
      acc(1'b1, terfe_pkg::REG_LCV_COUNT, 32'h0000_0000, v);
      q.delete();
      line(s, n);
      chk("stream", 32'h0000_0001, {31'h0, has(p, np)});
      acc(1'b0, terfe_pkg::REG_LCV_COUNT, 32'h0000_0000, v);
      chk("violations", cnt, v);
   endtask : run

   // Settle, then note which levels the system outputs took: {gap hi, gap lo,
   // sync hi, data hi, data lo}.
   task watch(output logic [4:0] s);
      int i;
      s = 5'h00;
      for (i = 0; i < 130; i++) begin
         @(negedge clk_sys);
         if (i >= 30) s = s | {gclk === 1'b1, gclk === 1'b0, fsync === 1'b1,
                               sdat === 1'b1, sdat === 1'b0};
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      int k;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      acc(1'b0, terfe_pkg::REG_CTRL, 32'h0000_0000, v);
      chk("ctrl reset", terfe_pkg::CTRL_RESET, v);
      acc(1'b0, 2'h3, 32'h0000_0000, v);
      chk("unmapped", 32'h0000_0000, v);
      acc(1'b1, terfe_pkg::REG_CTRL, 32'hffff_ffff, v);
      acc(1'b0, terfe_pkg::REG_CTRL, 32'h0000_0000, v);
      chk("ctrl mask", terfe_pkg::CTRL_WMASK, v);
      run(32'h0000_0009, 32'h0000_9a08, 8, 16'h00b2, 8, 1);
      run(32'h0000_0002, 32'h0000_0224, 5, 16'h0016, 5, 1);
      run(32'h0000_0000, 32'h0002_4482, 9, 16'h0108, 9, 0);
      run(32'h0000_000c, 32'h0008_0982, 10, 16'h0210, 10, 0);
      run(32'h0000_0019, 32'h0000_9a08, 8, 16'h00b2, 8, 1);
      acc(1'b0, terfe_pkg::REG_STATUS, 32'h0000_0000, v);
      chk("primed", 32'h0000_0001, {31'h0, v[terfe_pkg::STAT_PRIMED]});
      cfg(32'h0000_0089);
      q.delete();
      watch(seen);
      chk("forced ones", 32'h0000_0002, {30'h0, seen[1:0]});
      chk("internal zeros", 32'h0000_0000, {31'h0, has(16'h0001, 1)});
      cfg(32'h0000_0209);
      // Each alarm alone must raise the automatic all-ones output.
      for (k = 0; k < 4; k++) begin
         alarm <= terfe_pkg::terfe_alarm_t'(4'h1 << k);
         watch(seen);
         chk("auto ones", 32'h0000_0002, {30'h0, seen[1:0]});
         acc(1'b0, terfe_pkg::REG_STATUS, 32'h0000_0000, v);
         chk("auto flag", 32'h0000_0001, {31'h0, v[terfe_pkg::STAT_AUTO_ACTIVE]});
      end
      alarm <= '0;
      watch(seen);
      chk("auto ends", 32'h0000_0001, {30'h0, seen[1:0]});
      for (k = 0; k < 7; k++) begin
         cfg(gctl[k]);
         tpl <= terfe_pkg::terfe_tpl_t'(gtpl[k]);
         watch(seen);
         chk("gap sync", {29'h0, gexp[k]}, {29'h0, seen[4:2]});
      end
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: the sequence needs roughly 5000 cycles.
   initial begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      $display("Error watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule : terfe_receive_front_end_bench
`default_nettype wire
